// [logic/offset_trim_defs.svh]
// Purpose: register offsets, field positions and reset values of the trim bank
// Assumes: byte addresses on a 32-bit classic wishbone bus
// Notes:   none
`ifndef OFFSET_TRIM_DEFS_SVH
`define OFFSET_TRIM_DEFS_SVH
// printed offsets (register indexes); byte address is four times these
`define TRIM_A_IDX        12'h092
`define TRIM_B_IDX        12'h094
`define FILT_DC_IDX       12'h097
`define FILT_BW_IDX       12'h098
`define CAL_STATUS_IDX    12'h0a0
// field layout
`define TRIM_MSB          11
`define TRIM_W            12
`define DC_PRESERVE_BIT   0
`define BW_MSB            7
`define BW_LSB            4
`define SOAK_MSB          3
`define SOAK_LSB          0
// reset values
`define FILT_DC_RST       8'h00
`define FILT_BW_RST       8'h33
`define TRIM_FACTORY_RST  12'h800
`endif

// [logic/offset_trim_pkg.sv]
// Purpose: shared types of the offset trim register bank
// Assumes: nothing
// Notes:   none
package offset_trim_pkg;
  // wishbone request as seen by the slave
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [13:0] adr;
    logic [31:0] dat;
  } wb_req_t;
  // calibration status from the calibration engine
  typedef struct packed {
    logic offsetCalEnable;
    logic backgroundCalEnable;
    logic backgroundOffsetCalEnable;
    logic foregroundCalComplete;
    logic calibrationHalted;
    logic foregroundCalBusy;
  } cal_status_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;
endpackage : offset_trim_pkg

// [logic/offset_filter_mode.sv]
// Purpose: selects the dc behaviour of the offset filter
// Assumes: dcPreserve is registered by the caller; filterEnable is passed through unregistered
// Notes:   purely combinational
`timescale 1ns/1ps
module offset_filter_mode (
  // control
  input  wire logic       dcPreserve,
  input  wire logic       filterEnable,
  // to the filter datapath
  output logic            removeBankMismatch,
  output logic            removeCommonDc
);
  // preserve keeps common dc, clear removes all offsets
  always_comb begin
    removeBankMismatch = filterEnable;
    removeCommonDc     = filterEnable & ~dcPreserve;
  end
endmodule : offset_filter_mode

// [logic/offset_trim_regs.sv]
// Purpose: offset trim and offset filter control registers, wishbone slave
// Assumes: classic wishbone, one register per aligned 32-bit word
// Notes:   ack comes one cycle after the request is seen; writes land with ack
`timescale 1ns/1ps
`include "offset_trim_defs.svh"
module offset_trim_regs
  import offset_trim_pkg::*;
#(
  parameter logic [`TRIM_MSB:0] FACTORY_TRIM_A = `TRIM_FACTORY_RST,
  parameter logic [`TRIM_MSB:0] FACTORY_TRIM_B = `TRIM_FACTORY_RST
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // wishbone slave
  input  wire wb_req_t      wbReq,
  output logic [31:0]       wbDatOut,
  output logic              wbAck,
  // calibration engine
  input  wire cal_status_t  calStatus,
  input  wire logic         offsetFilterEnable,
  input  wire logic         inputBSelect,
  // to the converter core
  output logic [`TRIM_MSB:0] activeTrim,
  output logic [3:0]         filterBandwidthSelect,
  output logic [3:0]         filterSettleTimeSelect,
  output logic               removeBankMismatch,
  output logic               removeCommonDc
);
  // bus, trim, filter and read state
  bus_state_t              state_q, state_d;
  logic [`TRIM_MSB:0]      trimA_q, trimA_d;
  logic [`TRIM_MSB:0]      trimB_q, trimB_d;
  logic [7:0]              filtDc_q, filtDc_d;
  logic [7:0]              filtBw_q, filtBw_d;
  logic [31:0]             rdat_q, rdat_d;
  logic [11:0]             regIdx;
  logic                    req;
  logic [15:0]             wrHalf;
  logic                    taken;
  logic                    wrBeat;

  // word address of the request
  function automatic logic [11:0] wordIndex(input logic [13:0] adr);
    wordIndex = adr[13:2];
  endfunction : wordIndex

  // apply byte enables to the low sixteen bits
  function automatic logic [15:0] mergeHalf(input logic [15:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
    mergeHalf = old;
    if (sel[0]) begin
      mergeHalf[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      mergeHalf[15:8] = dat[15:8];
    end
  endfunction : mergeHalf

  assign regIdx = wordIndex(wbReq.adr);
  assign req    = wbReq.cyc & wbReq.stb;
  // a request is taken when idle; its write lands on the ack edge
  assign taken  = req & (state_q == BUS_IDLE);
  assign wrBeat = req & wbReq.we & (state_q == BUS_ACK);

  // bus handshake: take a request, answer for exactly one cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      BUS_IDLE: begin
        if (req) begin
          state_d = BUS_ACK;
        end
      end
      BUS_ACK: begin
        state_d = BUS_IDLE;                                // ack low a cycle
      end
      default: begin
        state_d = BUS_IDLE;
      end
    endcase
  end

  // bus state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= BUS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // trims change only on a write beat to their own word
  always_comb begin
    trimA_d = trimA_q;
    trimB_d = trimB_q;
    wrHalf  = 16'h0000;
    if (wrBeat) begin
      case (regIdx)
        `TRIM_A_IDX: begin
          wrHalf  = mergeHalf({4'h0, trimA_q}, wbReq.dat, wbReq.sel);
          trimA_d = wrHalf[`TRIM_MSB:0];
        end
        `TRIM_B_IDX: begin
          wrHalf  = mergeHalf({4'h0, trimB_q}, wbReq.dat, wbReq.sel);
          trimB_d = wrHalf[`TRIM_MSB:0];
        end
        default: begin
          wrHalf  = 16'h0000;                              // not a trim
        end
      endcase
    end
  end

  // trim registers; reserved bits 15-12 are never stored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trimA_q <= FACTORY_TRIM_A;
      trimB_q <= FACTORY_TRIM_B;
    end else begin
      trimA_q <= trimA_d;
      trimB_q <= trimB_d;
    end
  end

  // filter controls; only the byte lane of bits 7-0 counts
  always_comb begin
    filtDc_d = filtDc_q;
    filtBw_d = filtBw_q;
    if (wrBeat && wbReq.sel[0]) begin
      case (regIdx)
        `FILT_DC_IDX: begin
          filtDc_d = {7'h00, wbReq.dat[`DC_PRESERVE_BIT]};
        end
        `FILT_BW_IDX: begin
          filtBw_d = wbReq.dat[7:0];
        end
        default: begin
          filtDc_d = filtDc_q;
        end
      endcase
    end
  end

  // filter control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      filtDc_q <= `FILT_DC_RST;
      filtBw_q <= `FILT_BW_RST;
    end else begin
      filtDc_q <= filtDc_d;
      filtBw_q <= filtBw_d;
    end
  end

  // read data is captured when taken and stands while ack is high
  always_comb begin
    rdat_d = rdat_q;
    if (taken) begin
      rdat_d = 32'h0000_0000;
      case (regIdx)
        `TRIM_A_IDX: begin
          rdat_d[`TRIM_MSB:0] = trimA_q;
        end
        `TRIM_B_IDX: begin
          rdat_d[`TRIM_MSB:0] = trimB_q;
        end
        `FILT_DC_IDX: begin
          rdat_d[7:0] = {7'h00, filtDc_q[`DC_PRESERVE_BIT]};
        end
        `FILT_BW_IDX: begin
          rdat_d[7:0] = filtBw_q;
        end
        `CAL_STATUS_IDX: begin
          // status lets software honour the access windows
          rdat_d[5:0] = calStatus;
        end
        default: begin
          rdat_d = 32'h0000_0000;                          // unmapped reads 0
        end
      endcase
    end
  end

  // read data register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdat_q <= 32'h0000_0000;
    end else begin
      rdat_q <= rdat_d;
    end
  end

  // bus answer
  assign wbAck    = (state_q == BUS_ACK);
  assign wbDatOut = rdat_q;

  // trim follows the input the core is sampling
  assign activeTrim = inputBSelect ? trimB_q : trimA_q;
  assign filterBandwidthSelect  = filtBw_q[`BW_MSB:`BW_LSB];
  assign filterSettleTimeSelect = filtBw_q[`SOAK_MSB:`SOAK_LSB];

  // dc handling of the offset filter
  offset_filter_mode uMode (
    .dcPreserve         (filtDc_q[`DC_PRESERVE_BIT]),
    .filterEnable       (offsetFilterEnable),
    .removeBankMismatch (removeBankMismatch),
    .removeCommonDc     (removeCommonDc)
  );
endmodule : offset_trim_regs

// [dv/offset_trim_regs_sva.sv]
// Purpose: port checks of the trim bank
// Assumes: ack one cycle after a taken request
// Notes:   bound below
`timescale 1ns/1ps
module offset_trim_regs_sva
  import offset_trim_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // watched ports
  input wire wb_req_t     wbReq,
  input wire logic        wbAck,
  input wire logic        offsetFilterEnable,
  input wire logic        inputBSelect,
  input wire logic [11:0] activeTrim,
  input wire logic [3:0]  filterBandwidthSelect,
  input wire logic [3:0]  filterSettleTimeSelect,
  input wire logic        removeBankMismatch,
  input wire logic        removeCommonDc
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // full-word write beat, its address and its data; it lands with ack
  wire logic        wr = wbAck && wbReq.we && wbReq.sel == 4'hf;
  wire logic [13:0] ad = wbReq.adr;
  wire logic [11:0] wd = wbReq.dat[11:0];
  wire logic [7:0]  wdByte = wbReq.dat[7:0];
  wire logic        wdBit = wbReq.dat[0];
  property p_ack; wbReq.cyc && wbReq.stb && !wbAck |=> wbAck; endproperty
  a_ack: assert property (p_ack) else $error("late ack");
  property p_pulse; wbAck |=> !wbAck; endproperty
  a_pulse: assert property (p_pulse) else $error("long ack");
  property p_idle; !(wbReq.cyc && wbReq.stb) |=> !wbAck; endproperty
  a_idle: assert property (p_idle) else $error("stray ack");
  property p_trimA;
    wr && ad == 14'h248 && !inputBSelect |=> activeTrim == $past(wd);
  endproperty
  a_trimA: assert property (p_trimA) else $error("trim a");
  property p_trimB;
    wr && ad == 14'h250 && inputBSelect |=> activeTrim == $past(wd);
  endproperty
  a_trimB: assert property (p_trimB) else $error("trim b");
  property p_dc;
    wr && ad == 14'h25c |=> removeBankMismatch == offsetFilterEnable &&
      removeCommonDc == (offsetFilterEnable && !$past(wdBit));
  endproperty
  a_dc: assert property (p_dc) else $error("dc mode");
  property p_bw;
    wr && ad == 14'h260 |=> {filterBandwidthSelect,
      filterSettleTimeSelect} == $past(wdByte);
  endproperty
  a_bw: assert property (p_bw) else $error("bw soak");
  property p_rst;
    $rose(rst_n) |-> activeTrim == 12'h800 && filterBandwidthSelect == 4'h3
      && filterSettleTimeSelect == 4'h3 && removeCommonDc == offsetFilterEnable;
  endproperty
  a_rst: assert property (p_rst) else $error("reset");
  // main scenarios
  c_wr: cover property (wr);
  c_rd: cover property (wbAck && !wbReq.we);
  c_dc: cover property (removeCommonDc);
endmodule : offset_trim_regs_sva
bind offset_trim_regs offset_trim_regs_sva chk_u (.clk(clk), .rst_n(rst_n),
  .wbReq(wbReq), .wbAck(wbAck), .offsetFilterEnable(offsetFilterEnable),
  .inputBSelect(inputBSelect), .activeTrim(activeTrim),
  .filterBandwidthSelect(filterBandwidthSelect),
  .filterSettleTimeSelect(filterSettleTimeSelect),
  .removeBankMismatch(removeBankMismatch), .removeCommonDc(removeCommonDc));

// [dv/tb.sv]
// Purpose: self-checking bench of the trim bank
// Assumes: default factory trims
// Notes:   one request at a time
`timescale 1ns/1ps
module tb;
  import offset_trim_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  wb_req_t     req = '0;
  cal_status_t cal = 6'h24; // offsetCalEnable and foreground_cal_complete, no writes in cal
  logic        filtEn = 1'b1;
  logic        bSel = 1'b0;
  logic [3:0]  wrSel = 4'hf;
  logic [31:0] rd;
  logic [31:0] datOut;
  logic        ack;
  logic [11:0] trim;
  logic [3:0]  bw;
  logic [3:0]  soak;
  logic        bankRm;
  logic        dcRm;
  int          fails = 0;
  int          comparisons = 0;
  int          cycles = 0;
  offset_trim_regs dut_u (.clk(clk), .rst_n(rst_n), .wbReq(req),
    .wbDatOut(datOut), .wbAck(ack), .calStatus(cal),
    .offsetFilterEnable(filtEn), .inputBSelect(bSel), .activeTrim(trim),
    .filterBandwidthSelect(bw), .filterSettleTimeSelect(soak),
    .removeBankMismatch(bankRm), .removeCommonDc(dcRm));
  // clock and hang guard
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      fails++;
      stop_test();
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one classic cycle, waits for ack
  task wb(input logic w, input logic [13:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b1, w, wrSel, a, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = datOut;
    req <= '0;
    @(posedge clk);
  endtask : wb
  task t_reset;
    logic [13:0] a[5] = '{14'h248, 14'h250, 14'h25c, 14'h260, 14'h280};
    logic [31:0] e[5] = '{32'h800, 32'h800, 32'h0, 32'h33, 32'h24};
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, a[i], '0);
      chk("reset", rd, e[i]);
    end
  endtask : t_reset
  task t_trims;
    wb(1'b1, 14'h248, 32'hffff_fa5c);
    chk("muxA", {20'h0, trim}, 32'ha5c);
    bSel <= 1'b1;
    wb(1'b1, 14'h250, 32'h0000_0fff);
    chk("muxB", {20'h0, trim}, 32'hfff);
    wb(1'b0, 14'h248, '0);
    chk("trimA", rd, 32'ha5c);
    wrSel = 4'h1;
    wb(1'b1, 14'h248, 32'h0000_0b33);
    wrSel = 4'hf;
    wb(1'b0, 14'h248, '0);
    chk("byteA", rd, 32'ha33);
    bSel <= 1'b0;
    @(posedge clk);
    chk("muxA2", {20'h0, trim}, 32'ha33);
  endtask : t_trims
  // both background enables on: software only reads once halted
  task t_halt;
    cal <= 6'h1a;
    wb(1'b0, 14'h280, '0);
    chk("status", rd, 32'h1a);
    wb(1'b0, 14'h250, '0);
    chk("haltRd", rd, 32'hfff);
    cal <= 6'h24;
  endtask : t_halt
  // second reset at the end of the run brings back the factory values
  task t_rerst;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, 14'h248, '0);
    chk("rerstA", rd, 32'h800);
    chk("rerstBw", {24'h0, bw, soak}, 32'h33);
  endtask : t_rerst
  task t_dc;
    wb(1'b1, 14'h25c, 32'hff);
    chk("keepDc", {30'h0, bankRm, dcRm}, 32'h2);
    wb(1'b0, 14'h25c, '0);
    chk("dcCtrl", rd, 32'h1);
    wb(1'b1, 14'h25c, 32'h0);
    chk("dropDc", {30'h0, bankRm, dcRm}, 32'h3);
    filtEn <= 1'b0;
    @(posedge clk);
    chk("filtOff", {30'h0, bankRm, dcRm}, 32'h0);
    filtEn <= 1'b1;
  endtask : t_dc
  task t_misc;
    wb(1'b1, 14'h260, 32'h55);
    chk("bwSoak", {24'h0, bw, soak}, 32'h55);
    wb(1'b1, 14'h300, 32'hffff_ffff);
    wb(1'b0, 14'h300, '0);
    chk("unmapped", rd, 32'h0);
  endtask : t_misc
  task stop_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_trims();
    t_dc();
    t_halt();
    t_misc();
    t_rerst();
    stop_test();
  end
endmodule : tb
